// ==== design/pmac_acq_ctrl.v ====
// How it works
// (R1) Mode bit 5 selects normal or idle
// (R2) Idle converter acquires no samples at all
// (R3) After trigger: bit 4 picks idle/power-down
// (R4) Bit 3 picks triggered or continuous
// (R5) Writing mode register starts triggered cycle
// (R6) Mode field selects inputs; 3,5 forbidden
// (R7) Status reports progress only when triggered
// (R8) Ready bit meaningless in continuous mode
// (R9) Ready high while converting, low after
// (R10) Mode write reinitializes the ready bit
// (R11) Overflow flag on out-of-range current/power
// (R12) Conversion time code maps 64us to 2.048ms
// (R13) Shunt uses its own conversion time
// (R14) Averaging code gives 2^code, max 4096
// (R15) Averaging bits 6:3, time bits 2:0
// (R16) Gain write starts current/power compute
// (R17) Gain is 15 bits, bit 15 zero
// (R18) Shunt result is signed 15-bit
// (R19) Math uses 11-bit resolution with gain
// (R20) Bit 6 powers the converter down
// (R21) Continuous mode restarts sequence after pass
// (R22) Channel time is conversion time times averages
`timescale 1ns/100ps
`include "pmac_defines.vh"
module pmac_acq_ctrl #(
  parameter BASE_CYC = `PMAC_TCONV_BASE_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire [15:0] shunt_sample,
  input wire [15:0] bus_sample,
  output wire adc_powered,
  output wire adc_active,
  output reg [2:0] adc_channel,
  output reg sample_strobe
);
  // ----------------------------------------
  // Channel codes and states
  // ----------------------------------------
  localparam CH_SHUNT = 3'h0;
  localparam CH_VBUS = 3'h1;
  localparam CH_AUX = 3'h2;
  localparam CH_TEMP = 3'h3;
  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_DOWN = 3'b100;

  // Conversion time in units of the base period, 1 to 32
  function [5:0] conv_mult;
    input [2:0] code;
    begin
      case (code[2:1])
        2'b00: conv_mult = code[0] ? 6'h02 : 6'h01;
        2'b01: conv_mult = code[0] ? 6'h08 : 6'h04;
        2'b10: conv_mult = 6'h10;
        default: conv_mult = 6'h20;
      endcase
    end
  endfunction

  // Averaging exponent, codes 11xx clamp to 4096
  function [3:0] avg_exp;
    input [3:0] code;
    begin
      avg_exp = (code[3:2] == 2'b11) ? 4'hc : code;
    end
  endfunction

  // Next channel of a pass at or after the given one
  function [3:0] next_chan;
    input [2:0] op;
    input [2:0] from;
    reg [3:0] mask;
    reg [3:0] r;
    integer i;
    begin
      mask = 4'h0;
      r = 4'h8;
      case (op)
        `PMAC_OP_SHUNT: mask = 4'b0001;
        `PMAC_OP_VBUS: mask = 4'b0010;
        `PMAC_OP_SH_BUS: mask = 4'b0011;
        `PMAC_OP_AUX: mask = 4'b0100;
        `PMAC_OP_TEMP: mask = 4'b1000;
        `PMAC_OP_ALL: mask = 4'b1111;
        default: mask = 4'b0000;
      endcase
      for (i = 3; i >= 0; i = i - 1) begin
        if (mask[i] && (i >= from)) begin
          r = i[3:0];
        end
      end
      next_chan = r;
    end
  endfunction

  // ----------------------------------------
  // Bus capture
  // ----------------------------------------
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg [7:0] mode_q;
  reg [15:0] shcfg_q;
  reg [15:0] gain_q;
  reg conversion_ready_flag_q;
  reg ovf_q;
  reg [15:0] shunt_res_q;
  reg [15:0] curr_q;
  reg [15:0] powr_q;
  reg [2:0] state_q;
  reg [2:0] chan_q;
  reg [11:0] avg_cnt_q;
  reg [17:0] tick_q;
  reg [15:0] vbus_res_q;
  reg calc_q;
  reg pass_q;
  reg gain_wr_q;
  reg [31:0] shunt_acc_q;
  wire take = hsel & hready & htrans[1];
  wire [7:0] rd_addr = haddr;
  wire wr_mode = wr_pend_q && (wr_addr_q == `PMAC_ADDR_MODE);
  wire wr_gain = wr_pend_q && (wr_addr_q == `PMAC_ADDR_GAIN);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase latched; data lands one cycle later
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= take & hwrite;
      wr_addr_q <= haddr;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= `PMAC_MODE_RST;
      shcfg_q <= `PMAC_SHCFG_RST;
      gain_q <= `PMAC_GAIN_RST;
    end else begin
      // (R6) forbidden codes kept as written
      if (wr_mode) begin
        mode_q <= {1'b0, hwdata[6:0]};
      end
      // (R15) only low seven bits held
      if (wr_pend_q && (wr_addr_q == `PMAC_ADDR_SHCFG)) begin
        shcfg_q <= {9'h000, hwdata[6:0]};
      end
      // (R17) bit 15 reads zero
      if (wr_gain) begin
        gain_q <= {1'b0, hwdata[14:0]};
      end
    end
  end

  // ----------------------------------------
  // Acquisition sequencer
  // ----------------------------------------
  // (R4) triggered or continuous
  wire cont = mode_q[`PMAC_MODE_CONT];
  // Decode against the word being written so a trigger runs with its own settings
  wire [7:0] mode_use = wr_mode ? {1'b0, hwdata[6:0]} : mode_q;
  wire [3:0] first_ch = next_chan(mode_use[2:0], 3'h0);
  wire go = !mode_use[`PMAC_MODE_PWRDN] && !mode_use[`PMAC_MODE_IDLE] && !first_ch[3];
  wire [3:0] after_ch = next_chan(mode_q[2:0], chan_q + 3'h1);
  // (R13) shunt has its own timing; others use the default
  wire [2:0] t_code = (chan_q == CH_SHUNT) ? shcfg_q[2:0] : 3'h7;
  wire [3:0] a_code = (chan_q == CH_SHUNT) ? shcfg_q[6:3] : 4'h0;
  // (R12) period scaled from the base conversion time
  // Full base width kept; a real base period does not fit twelve bits
  wire [17:0] base_len = BASE_CYC[17:0];
  wire [17:0] conv_len = base_len * {12'h000, conv_mult(t_code)};
  // (R14) sample count is a power of two
  wire [11:0] avg_last = (12'h001 << avg_exp(a_code)) - 12'h001;
  wire avg_is_full = (avg_exp(a_code) == 4'hc);
  wire sample_end = (state_q == ST_CONV) && (tick_q == conv_len - 18'h1);
  wire chan_end = sample_end && (avg_cnt_q == avg_last) && !(avg_is_full && !avg_cnt_q[11]);
  wire [31:0] avg_sum = shunt_acc_q + {{16{shunt_sample[15]}}, shunt_sample};
  // Averaged code; arithmetic shift keeps the sign
  wire signed [31:0] avg_div = $signed(avg_sum) >>> avg_exp(a_code);
  wire pass_end = chan_end && after_ch[3];

  // Power down and idle gate every acquisition
  // (R20) power-down bit stops the converter
  assign adc_powered = !mode_q[`PMAC_MODE_PWRDN] && (state_q != ST_DOWN);
  // (R2) samples only while converting
  assign adc_active = (state_q == ST_CONV);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      chan_q <= CH_SHUNT;
      tick_q <= 18'h00000;
      avg_cnt_q <= 12'h000;
      sample_strobe <= 1'b0;
      adc_channel <= CH_SHUNT;
      shunt_acc_q <= 32'h00000000;
      shunt_res_q <= 16'h0000;
      vbus_res_q <= 16'h0000;
    end else begin
      sample_strobe <= sample_end;
      case (state_q)
        ST_IDLE, ST_DOWN: begin
          tick_q <= 18'h00000;
          avg_cnt_q <= 12'h000;
          shunt_acc_q <= 32'h00000000;
          // (R1) idle bit holds the converter still
          // Continuous mode starts on its own
          if (go && cont) begin
            state_q <= ST_CONV;
            chan_q <= first_ch[2:0];
            adc_channel <= first_ch[2:0];
          end
        end
        ST_CONV: begin
          if (mode_q[`PMAC_MODE_PWRDN] || mode_q[`PMAC_MODE_IDLE]) begin
            state_q <= mode_q[`PMAC_MODE_PWRDN] ? ST_DOWN : ST_IDLE;
          end else if (sample_end) begin
            tick_q <= 18'h00000;
            if (chan_q == CH_SHUNT) begin
              shunt_acc_q <= avg_sum;
            end
            // (R22) time times averages per channel
            if (chan_end) begin
              avg_cnt_q <= 12'h000;
              shunt_acc_q <= 32'h00000000;
              // (R14) averaged shunt result stored
              if (chan_q == CH_SHUNT) begin
                shunt_res_q <= avg_div[15:0];
              end
              if (chan_q == CH_VBUS) begin
                vbus_res_q <= bus_sample;
              end
              if (after_ch[3]) begin
                chan_q <= first_ch[2:0];
                adc_channel <= first_ch[2:0];
                // (R3) post-trigger state choice
                // (R21) continuous restarts the pass
                if (!cont) begin
                  state_q <= mode_q[`PMAC_MODE_POST] ? ST_DOWN : ST_IDLE;
                end
              end else begin
                chan_q <= after_ch[2:0];
                adc_channel <= after_ch[2:0];
              end
            end else begin
              avg_cnt_q <= avg_cnt_q + 12'h001;
            end
          end else begin
            tick_q <= tick_q + 18'h00001;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      // (R5) mode write starts pass
      // A write mid-pass restarts from the first channel rather than mixing old and new settings
      if (wr_mode) begin
        tick_q <= 18'h00000;
        avg_cnt_q <= 12'h000;
        shunt_acc_q <= 32'h00000000;
        if (go) begin
          state_q <= ST_CONV;
          chan_q <= first_ch[2:0];
          adc_channel <= first_ch[2:0];
        end else begin
          state_q <= mode_use[`PMAC_MODE_PWRDN] ? ST_DOWN : ST_IDLE;
        end
      end
    end
  end

  // ----------------------------------------
  // Status and math
  // ----------------------------------------
  // (R18) signed 15-bit shunt code with sign extension
  wire signed [15:0] sh_s = {shunt_res_q[15], shunt_res_q[14:0]};
  // (R19) gain product scaled by 2^11
  wire signed [32:0] cur_full = (sh_s * $signed({1'b0, gain_q[14:0]})) >>> `PMAC_MATH_SHIFT;
  wire signed [48:0] pow_full = (cur_full * $signed({1'b0, vbus_res_q})) >>> `PMAC_MATH_SHIFT;
  wire cur_ovf = (cur_full > 33'sd32767) || (cur_full < -33'sd32768);
  wire pow_ovf = (pow_full > 49'sd32767) || (pow_full < -49'sd32768);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conversion_ready_flag_q <= 1'b0;
      ovf_q <= 1'b0;
      calc_q <= 1'b0;
      pass_q <= 1'b0;
      gain_wr_q <= 1'b0;
      curr_q <= 16'h0000;
      powr_q <= 16'h0000;
    end else begin
      // Results and gain land first; the math runs one cycle later on the new values
      pass_q <= pass_end && !wr_mode;
      gain_wr_q <= wr_gain;
      // (R16) gain write arms the calculation
      if (wr_gain) begin
        calc_q <= 1'b1;
      end
      // (R9) ready high during, low after transfer
      // (R10) mode write reinitializes it
      if (wr_mode) begin
        conversion_ready_flag_q <= go && !hwdata[`PMAC_MODE_CONT];
      end else if (pass_q) begin
        conversion_ready_flag_q <= 1'b0;
      end
      // Math refreshes after a gain write and, once gain has been written, after each finished pass
      if (calc_q && (gain_wr_q || pass_q)) begin
        curr_q <= cur_full[15:0];
        powr_q <= pow_full[15:0];
        // (R11) out of range flags the result
        ovf_q <= cur_ovf || pow_ovf || (gain_q[14:0] == 15'h0000);
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Read data is registered so the answer stands in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      case (rd_addr)
        `PMAC_ADDR_GAIN: hrdata <= {16'h0000, gain_q};
        `PMAC_ADDR_MODE: hrdata <= {24'h000000, mode_q};
        // (R7) (R8) progress only shown in triggered mode
        `PMAC_ADDR_STAT: hrdata <= {30'h0, conversion_ready_flag_q && !cont, ovf_q};
        `PMAC_ADDR_SHCFG: hrdata <= {16'h0000, shcfg_q};
        `PMAC_ADDR_SAMPLE: hrdata <= {16'h0000, shunt_res_q};
        `PMAC_ADDR_CURR: hrdata <= {16'h0000, curr_q};
        `PMAC_ADDR_POWR: hrdata <= {16'h0000, powr_q};
        `PMAC_ADDR_CHAN: hrdata <= {27'h0, state_q, 2'b00} | {29'h0, chan_q};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end
endmodule // pmac_acq_ctrl

// ==== dv/adc_acquisition_control_test.sv ====
`timescale 1ns/100ps
`include "pmac_defines.vh"
module adc_acquisition_control_test;
  localparam int BASE = 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rdat, g, cur;
  logic hreadyout, hresp, adc_powered, adc_active, sample_strobe;
  logic [2:0] adc_channel;
  logic [15:0] sh_v = 16'h0, bus_v = 16'h0, shunt_sample, bus_sample;
  logic [31:0] seed = 32'h416eff49;
  logic [31:0] exp_q[$], msk_q[$];
  int fails = 0, samples_checked = 0, dur, ns;
  int mul[8] = '{1, 2, 4, 8, 16, 16, 32, 32};
  int cnt[6] = '{1, 1, 2, 1, 1, 4};
  logic [2:0] ops[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
  event rd_ev;
  always #4 hclk = ~hclk;
  pmac_acq_ctrl #(.BASE_CYC(BASE)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .shunt_sample,
    .bus_sample, .adc_powered, .adc_active, .adc_channel, .sample_strobe);
  pmac_conv_model u_conv (.shunt_val(sh_v), .bus_val(bus_v), .shunt_sample, .bus_sample);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    samples_checked++;
    if (v !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, v);
    end
  endtask
  // One single transfer; address held until hready, data held until hready again
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    xfer(1'b0, a, 32'h0);
    ->rd_ev;
    // Let the checking process take the note before going on
    wait (exp_q.size() == 0);
  endtask
  // Read data is judged against the oldest note as soon as it lands
  always @(rd_ev) chk("hrdata", exp_q.pop_front(), rdat & msk_q.pop_front());
  // Trigger a pass, then count busy cycles and samples; a trailing window catches a late strobe
  task automatic run(input logic [7:0] m);
    xfer(1'b1, `PMAC_ADDR_MODE, {24'h0, m});
    dur = 0;
    ns = 0;
    for (int i = 0; i < 20000; i++) begin
      @(posedge hclk);
      ns += sample_strobe;
      dur += adc_active;
      if (dur > 0 && adc_active !== 1'b1) break;
    end
    repeat (3) begin
      @(posedge hclk);
      ns += sample_strobe;
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard sized well above the longest averaging pass
  initial begin
    #(8 * 60000);
    fails++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`PMAC_ADDR_MODE, 32'h0a, 32'hff);
    rd(`PMAC_ADDR_SHCFG, 32'h7, 32'h7f);
    rd(`PMAC_ADDR_GAIN, 32'h0, 32'hffff);
    rd(`PMAC_ADDR_STAT, 32'h0, 32'h3);
    rd(8'h10, 32'h0, 32'hffffffff);
    xfer(1'b1, `PMAC_ADDR_GAIN, 32'hffff);
    rd(`PMAC_ADDR_GAIN, 32'h7fff, 32'hffff);
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, `PMAC_ADDR_SHCFG, c);
      run(8'h00);
      chk("shunt time", BASE * mul[c], dur);
    end
    for (int k = 0; k < 5; k++) begin
      xfer(1'b1, `PMAC_ADDR_SHCFG, (k == 4 ? 13 : k) << 3);
      run(8'h00);
      chk("averages", k == 4 ? 4096 : 1 << k, ns);
    end
    xfer(1'b1, `PMAC_ADDR_SHCFG, 32'h0);
    for (int k = 0; k < 6; k++) begin
      run({5'h0, ops[k]});
      chk("samples", cnt[k], ns);
    end
    xfer(1'b1, `PMAC_ADDR_SHCFG, 32'h7);
    xfer(1'b1, `PMAC_ADDR_MODE, 32'h0);
    rd(`PMAC_ADDR_STAT, 32'h2, 32'h2);
    run(8'h00);
    rd(`PMAC_ADDR_STAT, 32'h0, 32'h2);
    chk("powered", 32'h1, adc_powered);
    run(8'h10);
    chk("powered", 32'h0, adc_powered);
    xfer(1'b1, `PMAC_ADDR_SHCFG, 32'h0);
    for (int k = 0; k < 3; k++) begin
      xfer(1'b1, `PMAC_ADDR_MODE, k == 0 ? 32'h28 : (k == 1 ? 32'h08 : 32'h48));
      ns = 0;
      repeat (60) begin
        @(posedge hclk);
        ns += sample_strobe;
      end
      chk("continuous", k == 1, ns > 8);
    end
    g = rnd();
    // Shunt kept at 3072 or more so that the full gain later overflows the current
    sh_v <= {4'h0, 2'b11, g[9:0]};
    bus_v <= {4'h0, g[27:16]};
    cur = rnd();
    g = {21'h0, cur[10:0] | 11'h1};
    xfer(1'b1, `PMAC_ADDR_GAIN, g);
    run(8'h02);
    cur = ({20'h0, sh_v[11:0]} * g) >> 11;
    rd(`PMAC_ADDR_CURR, cur, 32'hffff);
    rd(`PMAC_ADDR_POWR, (cur * {16'h0, bus_v}) >> 11, 32'hffff);
    rd(`PMAC_ADDR_STAT, 32'h0, 32'h1);
    // Full gain on a large shunt code leaves the current out of range
    xfer(1'b1, `PMAC_ADDR_GAIN, 32'h7fff);
    rd(`PMAC_ADDR_STAT, 32'h1, 32'h1);
    chk("hresp", 32'h0, {31'h0, hresp});
    // Reset after the last pass puts mode, gain and status back
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`PMAC_ADDR_MODE, 32'h0a, 32'hff);
    rd(`PMAC_ADDR_GAIN, 32'h0, 32'hffff);
    rd(`PMAC_ADDR_STAT, 32'h0, 32'h3);
    test_done;
  end
endmodule // adc_acquisition_control_test

// ==== dv/pmac_acq_asserts.sv ====
`timescale 1ns/100ps
`include "pmac_defines.vh"
module pmac_acq_asserts #(
  parameter BASE_CYC = 4
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire adc_powered,
  input wire adc_active,
  input wire [2:0] adc_channel,
  input wire sample_strobe
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic w_q;
  logic [7:0] a_q, mode_q;
  logic [3:0] age_q;
  logic [15:0] gap_q;
  wire rd = hsel & hready & htrans[1] & ~hwrite;
  wire mw = w_q && a_q == `PMAC_ADDR_MODE;
  wire [2:0] op = mode_q[2:0];
  // Shadow of the mode register, its age, and the spacing of samples
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_q <= 1'b0;
      a_q <= 8'h00;
      mode_q <= `PMAC_MODE_RST;
      age_q <= 4'h0;
      gap_q <= 16'hffff;
    end else begin
      w_q <= hsel & hready & htrans[1] & hwrite;
      a_q <= haddr;
      age_q <= mw ? 4'h0 : (age_q == 4'hf ? age_q : age_q + 4'h1);
      if (mw) mode_q <= hwdata[7:0];
      gap_q <= sample_strobe ? 16'h0 : (gap_q == 16'hffff ? gap_q : gap_q + 16'h1);
    end
  end
  AST_TRIG_START: assert property (
    mw && hwdata[6:3] == 4'h0 && hwdata[2:0] != 3'h3 && hwdata[2:0] != 3'h5 |-> ##[1:3] adc_active)
    else $error("triggered pass did not start");
  AST_IDLE_QUIET: assert property (
    mode_q[5] && age_q > 4'h3 |-> !sample_strobe && !adc_active) else $error("idle converter sampled");
  AST_PWRDN: assert property (
    mode_q[6] && age_q > 4'h3 |-> !adc_powered && !sample_strobe) else $error("converter not powered down");
  AST_POST_PD: assert property (
    $fell(adc_active) && mode_q[4:3] == 2'b10 && age_q > 4'h2 |-> ##[0:2] !adc_powered)
    else $error("no power down after trigger");
  AST_POST_IDLE: assert property (
    $fell(adc_active) && mode_q[6:3] == 4'h0 && age_q > 4'h2 |-> adc_powered [*4])
    else $error("power lost after idle trigger");
  AST_CHAN_MAP: assert property (
    sample_strobe && age_q > 4'h3 && op != 3'h2 && op != 3'h7
    |-> adc_channel == (op[2] ? (op[1] ? 3'h3 : 3'h2) : {2'b00, op[0]})) else $error("wrong channel");
  AST_STROBE_ACT: assert property (
    sample_strobe |-> $past(adc_active) || $past(adc_active, 2)) else $error("sample outside conversion");
  AST_GAP: assert property (
    sample_strobe |-> gap_q >= BASE_CYC - 1) else $error("samples closer than one base time");
  AST_UNMAPPED: assert property (
    rd && haddr < `PMAC_ADDR_GAIN |=> hrdata == 32'h0) else $error("unmapped read not zero");
  AST_GAIN_TOP: assert property (
    rd && haddr == `PMAC_ADDR_GAIN |=> hrdata[31:15] == 17'h0) else $error("gain top bit set");
  AST_CONT_RDY: assert property (
    rd && haddr == `PMAC_ADDR_STAT && mode_q[3] |=> !hrdata[1]) else $error("ready set in continuous");
  cover property (mw);
  cover property ($fell(adc_active));
  cover property (sample_strobe && adc_channel == 3'h3);
endmodule // pmac_acq_asserts
bind pmac_acq_ctrl pmac_acq_asserts #(.BASE_CYC(BASE_CYC)) u_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .adc_powered, .adc_active, .adc_channel, .sample_strobe);

// ==== dv/pmac_conv_model.sv ====
`timescale 1ns/100ps
module pmac_conv_model (
  input wire [15:0] shunt_val,
  input wire [15:0] bus_val,
  output logic [15:0] shunt_sample,
  output logic [15:0] bus_sample
);
  // signed shunt range
  // Sign bit copied up; a live converter output never idles, so no release pattern
  always_comb shunt_sample = {shunt_val[14], shunt_val[14:0]};
  // Bus channel is plain unsigned
  always_comb bus_sample = bus_val;
endmodule // pmac_conv_model

// ==== shared/pmac_defines.vh ====
`ifndef PMAC_DEFINES_VH
`define PMAC_DEFINES_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PMAC_ADDR_GAIN 8'h38
`define PMAC_ADDR_MODE 8'hd2
`define PMAC_ADDR_STAT 8'hd3
`define PMAC_ADDR_SHCFG 8'hd4
`define PMAC_ADDR_SAMPLE 8'he0
`define PMAC_ADDR_CURR 8'he4
`define PMAC_ADDR_POWR 8'he8
`define PMAC_ADDR_CHAN 8'hec
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PMAC_MODE_PWRDN 6
`define PMAC_MODE_IDLE 5
`define PMAC_MODE_POST 4
`define PMAC_MODE_CONT 3
`define PMAC_STAT_CONVERSION_READY_FLAG 1
`define PMAC_STAT_OVF 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PMAC_MODE_RST 8'h0a
`define PMAC_SHCFG_RST 16'h0007
`define PMAC_GAIN_RST 16'h0000
// ----------------------------------------
// Operating mode codes
// ----------------------------------------
`define PMAC_OP_SHUNT 3'h0
`define PMAC_OP_VBUS 3'h1
`define PMAC_OP_SH_BUS 3'h2
`define PMAC_OP_AUX 3'h4
`define PMAC_OP_TEMP 3'h6
`define PMAC_OP_ALL 3'h7
// ----------------------------------------
// Timing
// ----------------------------------------
`define PMAC_CLK_MHZ 125
`define PMAC_TCONV_BASE_US 64
`define PMAC_TCONV_BASE_CYC (`PMAC_TCONV_BASE_US * `PMAC_CLK_MHZ)
`define PMAC_MATH_SHIFT 11
`endif
